// *** verilog/u0pr_top.sv ***
// pin routing for serial channel zero with its baud rate timer
`timescale 1ns/1ps
`default_nettype none
module u0pr_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic line_connect_mode,
  input wire logic serial_out_select,
  input wire logic serial_in_select,
  input wire logic tx_open_drain_sel,
  input wire logic tx_pin_direction,
  input wire logic rx_pin_direction,
  input wire logic tx_pin_pullup,
  input wire logic port_pullup_one,
  input wire logic port_out_zero,
  input wire logic port_out_one,
  input wire logic serial_tx_line,
  input wire logic baud_run,
  input wire logic [7:0] baud_compare,
  input wire logic port_pin_zero_i,
  input wire logic port_pin_one_i,
  output logic port_pin_zero_o,
  output logic port_pin_zero_oe,
  output logic port_pin_zero_pu,
  output logic port_pin_one_o,
  output logic port_pin_one_oe,
  output logic port_pin_one_pu,
  output logic serial_rx_line,
  output logic port_in_zero,
  output logic port_in_one,
  output logic baud_overflow,
  output logic baud_bit_tick,
  output u0pr_pkg::u0pr_role_t pin_zero_role
);
  // ==========================================================
  // pin synchronisers
  logic p0_s1_reg;
  logic p1_s1_reg;
  logic p0_s2_reg;
  logic p1_s2_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      p0_s1_reg <= 1'b1;
      p1_s1_reg <= 1'b1;
      p0_s2_reg <= 1'b1;
      p1_s2_reg <= 1'b1;
    end else begin
      p0_s1_reg <= port_pin_zero_i;
      p1_s1_reg <= port_pin_one_i;
      p0_s2_reg <= p0_s1_reg;
      p1_s2_reg <= p1_s1_reg;
    end
  end
  assign port_in_zero = p0_s2_reg;
  assign port_in_one = p1_s2_reg;

  // ==========================================================
  // pin multiplexer
  // registered so that a config change never glitches the pin
  logic p0_o_next;
  logic p0_oe_next;
  logic p0_pu_next;
  logic p1_o_next;
  logic p1_oe_next;
  logic p1_pu_next;
  logic rx_next;
  u0pr_pkg::u0pr_role_t role_next;
  logic p0_o_reg;
  logic p0_oe_reg;
  logic p0_pu_reg;
  logic p1_o_reg;
  logic p1_oe_reg;
  logic p1_pu_reg;
  logic rx_reg;
  u0pr_pkg::u0pr_role_t role_reg;

  always_comb begin
    // pin zero: serial output, shared serial input or port
    if (serial_out_select && tx_pin_direction) begin
      role_next = u0pr_pkg::U0PR_ROLE_SER_OUT;
    end else if (line_connect_mode && serial_in_select) begin
      role_next = u0pr_pkg::U0PR_ROLE_SER_IN;
    end else begin
      role_next = u0pr_pkg::U0PR_ROLE_PORT;
    end
    p0_pu_next = tx_pin_pullup;
    case (role_next)
      u0pr_pkg::U0PR_ROLE_SER_OUT: begin
        // open drain only ever pulls low; high comes from the pull-up
        p0_o_next = tx_open_drain_sel ? 1'b0 : serial_tx_line;
        p0_oe_next = tx_open_drain_sel ? ~serial_tx_line : 1'b1;
      end
      u0pr_pkg::U0PR_ROLE_SER_IN: begin
        p0_o_next = u0pr_pkg::PIN_OUT_RST;
        p0_oe_next = 1'b0;
      end
      u0pr_pkg::U0PR_ROLE_PORT: begin
        p0_o_next = port_out_zero;
        p0_oe_next = tx_pin_direction;
      end
      default: begin
        p0_o_next = u0pr_pkg::PIN_OUT_RST;
        p0_oe_next = u0pr_pkg::PIN_OE_RST;
      end
    endcase
    // pin one: serial input only in two-wire mode
    if (!line_connect_mode && serial_in_select) begin
      p1_o_next = u0pr_pkg::PIN_OUT_RST;
      p1_oe_next = 1'b0;
      p1_pu_next = 1'b0;
    end else begin
      p1_o_next = port_out_one;
      p1_oe_next = rx_pin_direction;
      p1_pu_next = port_pullup_one;
    end
    // receive source; idle level when deselected or own pin drives
    if (!serial_in_select) begin
      rx_next = u0pr_pkg::RX_IDLE;
    end else if (line_connect_mode) begin
      // a single wire that we drive cannot also be listened to
      rx_next = (role_next == u0pr_pkg::U0PR_ROLE_SER_IN) ?
                p0_s2_reg : u0pr_pkg::RX_IDLE;
    end else begin
      rx_next = p1_s2_reg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      p0_o_reg <= u0pr_pkg::PIN_OUT_RST;
      p0_oe_reg <= u0pr_pkg::PIN_OE_RST;
      p0_pu_reg <= 1'b0;
      p1_o_reg <= u0pr_pkg::PIN_OUT_RST;
      p1_oe_reg <= u0pr_pkg::PIN_OE_RST;
      p1_pu_reg <= 1'b0;
      rx_reg <= u0pr_pkg::RX_IDLE;
      role_reg <= u0pr_pkg::U0PR_ROLE_PORT;
    end else begin
      p0_o_reg <= p0_o_next;
      p0_oe_reg <= p0_oe_next;
      p0_pu_reg <= p0_pu_next;
      p1_o_reg <= p1_o_next;
      p1_oe_reg <= p1_oe_next;
      p1_pu_reg <= p1_pu_next;
      rx_reg <= rx_next;
      role_reg <= role_next;
    end
  end
  assign port_pin_zero_o = p0_o_reg;
  assign port_pin_zero_oe = p0_oe_reg;
  assign port_pin_zero_pu = p0_pu_reg;
  assign port_pin_one_o = p1_o_reg;
  assign port_pin_one_oe = p1_oe_reg;
  assign port_pin_one_pu = p1_pu_reg;
  assign serial_rx_line = rx_reg;
  assign pin_zero_role = role_reg;

  // ==========================================================
  // baud timer: core_clk stands in for the oscillator
  logic [7:0] timer_next;
  logic [7:0] timer_reg;
  logic [3:0] ovf_cnt_next;
  logic [3:0] ovf_cnt_reg;
  logic ovf_next;
  logic ovf_reg;
  logic bit_next;
  logic bit_reg;
  logic wrap;
  always_comb begin
    wrap = baud_run && (timer_reg == baud_compare);
    timer_next = u0pr_pkg::TIMER_RST;
    ovf_cnt_next = u0pr_pkg::OVF_CNT_RST;
    if (baud_run) begin
      timer_next = wrap ? u0pr_pkg::TIMER_RST : timer_reg + 8'h01;
      ovf_cnt_next = wrap ? ovf_cnt_reg + 4'h1 : ovf_cnt_reg;
    end
    ovf_next = wrap;
    bit_next = wrap && (ovf_cnt_reg == u0pr_pkg::OVF_LAST);
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timer_reg <= u0pr_pkg::TIMER_RST;
      ovf_cnt_reg <= u0pr_pkg::OVF_CNT_RST;
      ovf_reg <= 1'b0;
      bit_reg <= 1'b0;
    end else begin
      timer_reg <= timer_next;
      ovf_cnt_reg <= ovf_cnt_next;
      ovf_reg <= ovf_next;
      bit_reg <= bit_next;
    end
  end
  assign baud_overflow = ovf_reg;
  assign baud_bit_tick = bit_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  tx_push_pull_a: assert property (
    serial_out_select && tx_pin_direction && !tx_open_drain_sel |=>
    port_pin_zero_oe && port_pin_zero_o == $past(serial_tx_line))
    else $error("push-pull transmit not on pin zero");
  tx_open_drain_a: assert property (
    serial_out_select && tx_pin_direction && tx_open_drain_sel |=>
    port_pin_zero_oe == !$past(serial_tx_line) && !port_pin_zero_o)
    else $error("open drain transmit level wrong");
  rx_idle_one_a: assert property (
    !serial_in_select |=> serial_rx_line)
    else $error("deselected receive not reading one");
  tx_mode_same_a: assert property (
    serial_out_select && tx_pin_direction |=>
    pin_zero_role == u0pr_pkg::U0PR_ROLE_SER_OUT)
    else $error("transmit setup depends on line mode");
  two_wire_rx_a: assert property (
    serial_in_select && !line_connect_mode |=>
    serial_rx_line == $past(p1_s2_reg) && !port_pin_one_oe)
    else $error("two-wire receive not from pin one");
  one_wire_rx_a: assert property (
    serial_in_select && line_connect_mode && !tx_pin_direction |=>
    serial_rx_line == $past(p0_s2_reg) && !port_pin_zero_oe)
    else $error("single-wire receive not from pin zero");
  pin_one_port_a: assert property (
    line_connect_mode && rx_pin_direction |=>
    port_pin_one_oe && port_pin_one_o == $past(port_out_one))
    else $error("pin one not a port in single-wire mode");
  // a shared single-wire receive pin is forced to input whatever its dir
  pin_zero_port_a: assert property (
    !serial_out_select && tx_pin_direction &&
    !(line_connect_mode && serial_in_select) |=>
    port_pin_zero_oe && port_pin_zero_o == $past(port_out_zero))
    else $error("pin zero port output wrong");
  timer_ovf_a: assert property (
    baud_run && timer_reg == baud_compare |=>
    baud_overflow && timer_reg == u0pr_pkg::TIMER_RST)
    else $error("timer did not overflow at compare");
  // while baud_run holds, the count is back at zero only right after the sixteenth overflow
  bit_tick_a: assert property (
    baud_bit_tick ==
    (baud_overflow && ovf_cnt_reg == u0pr_pkg::OVF_CNT_RST))
    else $error("bit tick not on the sixteenth overflow");

  one_wire_rx_c: cover property (
    role_reg == u0pr_pkg::U0PR_ROLE_SER_IN && serial_in_select);
  duplex_c: cover property (
    role_reg == u0pr_pkg::U0PR_ROLE_SER_OUT && !line_connect_mode &&
    serial_in_select);
  bit_tick_c: cover property (baud_bit_tick);
endmodule : u0pr_top
`default_nettype wire

// *** verilog/u0pr_pkg.sv ***
// constants for the serial channel zero pin routing and baud timer
// Operation
// - transmit drives pin zero; two-wire receive reads one
// - transmit pin setup same in both modes
// - two-wire receive takes input from pin one
// - single-wire receive uses pin zero as input
// - single-wire mode leaves pin one as port
// - full duplex: pin zero out, pin one in
// - mode bit plus separate in/out select bits
// - table compare value yields listed bit rate
// - bit period is (compare+1) times two times eight
package u0pr_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned RATE_MAX_KBPS = 300;
  localparam int unsigned CMP_W = 8;
  localparam int unsigned OVF_PER_HALF = 2;
  localparam int unsigned PRE_DIV = 8;
  localparam int unsigned OVF_PER_BIT = OVF_PER_HALF * PRE_DIV;
  localparam logic [3:0] OVF_LAST = 4'(OVF_PER_BIT - 1);
  // example compare values at an 8 MHz timer clock
  localparam logic [7:0] CMP_EX_9615 = 8'h33;
  localparam logic [7:0] CMP_EX_31250 = 8'h0f;
  // ==========================================================
  // reset values
  localparam logic [7:0] TIMER_RST = 8'h00;
  localparam logic [3:0] OVF_CNT_RST = 4'h0;
  localparam logic PIN_OUT_RST = 1'b1;
  localparam logic PIN_OE_RST = 1'b0;
  localparam logic RX_IDLE = 1'b1;
  // ==========================================================
  // role of pin zero
  typedef enum logic [2:0] {
    U0PR_ROLE_PORT = 3'b001,
    U0PR_ROLE_SER_OUT = 3'b010,
    U0PR_ROLE_SER_IN = 3'b100
  } u0pr_role_t;
endpackage : u0pr_pkg

// *** test/u0pr_remote.sv ***
// remote serial transceiver model with pin wire resolution
`timescale 1ns/1ps
`default_nettype none
module u0pr_remote (
  input wire logic core_clk,
  input wire logic z_o,
  input wire logic z_oe,
  input wire logic z_pu,
  input wire logic o_o,
  input wire logic o_oe,
  input wire logic o_pu,
  input wire logic rem_on_zero,
  input wire logic rem_on_one,
  input wire logic rem_val,
  output logic pin_zero,
  output logic pin_one
);
  // a floating pin toggles so a stale level can never look valid
  logic flip = 1'b0;
  always @(posedge core_clk) flip <= ~flip;
  always_comb begin
    pin_zero = z_oe ? z_o : rem_on_zero ? rem_val : z_pu ? 1'b1 : flip;
    pin_one = o_oe ? o_o : rem_on_one ? rem_val : o_pu ? 1'b1 : flip;
  end
endmodule : u0pr_remote
`default_nettype wire

// *** test/u0pr_top_tb.sv ***
// self-checking bench for serial channel zero pin routing and baud
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_count++; $display("FAIL %s exp %0h got %0h", n, e, g); end end
module u0pr_top_tb;
  localparam int OSC_HZ = 8000000;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic line_connect_mode, serial_out_select, serial_in_select;
  logic tx_open_drain_sel, tx_pin_direction, rx_pin_direction;
  logic tx_pin_pullup, port_pullup_one, port_out_zero, port_out_one;
  logic serial_tx_line, baud_run, rem_on_zero, rem_on_one, rem_val;
  logic [7:0] baud_compare;
  logic port_pin_zero_i, port_pin_one_i, port_pin_zero_o;
  logic port_pin_zero_oe, port_pin_zero_pu, port_pin_one_o;
  logic port_pin_one_oe, port_pin_one_pu, serial_rx_line;
  logic port_in_zero, port_in_one, baud_overflow, baud_bit_tick;
  u0pr_pkg::u0pr_role_t pin_zero_role;
  int err_count = 0;
  int total_checks = 0;
  int n;
  int k;
  always #25 core_clk = ~core_clk;
  u0pr_top u0pr_top_inst (.core_clk, .rst, .line_connect_mode,
    .serial_out_select, .serial_in_select, .tx_open_drain_sel,
    .tx_pin_direction, .rx_pin_direction, .tx_pin_pullup,
    .port_pullup_one, .port_out_zero, .port_out_one, .serial_tx_line,
    .baud_run, .baud_compare, .port_pin_zero_i, .port_pin_one_i,
    .port_pin_zero_o, .port_pin_zero_oe, .port_pin_zero_pu,
    .port_pin_one_o, .port_pin_one_oe, .port_pin_one_pu, .serial_rx_line,
    .port_in_zero, .port_in_one, .baud_overflow, .baud_bit_tick,
    .pin_zero_role);
  u0pr_remote u0pr_remote_inst (.core_clk, .z_o(port_pin_zero_o),
    .z_oe(port_pin_zero_oe), .z_pu(port_pin_zero_pu),
    .o_o(port_pin_one_o), .o_oe(port_pin_one_oe), .o_pu(port_pin_one_pu),
    .rem_on_zero, .rem_on_one, .rem_val, .pin_zero(port_pin_zero_i),
    .pin_one(port_pin_one_i));
  // ====================
  // access tasks
  task cfg(input logic [9:0] c);
    {line_connect_mode, serial_out_select, serial_in_select,
     tx_open_drain_sel, tx_pin_direction, rx_pin_direction, tx_pin_pullup,
     port_pullup_one, port_out_zero, port_out_one} = c;
  endtask : cfg
  task tick(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : tick
  task test_done;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  // the whole run needs about 2250 cycles; the 6000-cycle limit allows over twice that
  initial begin
    #300000;
    err_count++;
    test_done();
  end
  // ====================
  // stimulus
  initial begin
    cfg(10'h000);
    serial_tx_line = 1'b1;
    baud_run = 1'b0;
    baud_compare = 8'h00;
    rem_on_zero = 1'b0;
    rem_on_one = 1'b1;
    rem_val = 1'b0;
    tick(12);
    `CHK("rst_oe", 1'b0, port_pin_zero_oe)
    `CHK("rst_rx", 1'b1, serial_rx_line)
    rst = 1'b0;
    for (int m = 0; m < 8; m++) begin
      // connected lines also enable receive: own transmit is not heard
      cfg({m[2], 1'b1, m[2], m[1], 6'b101000});
      serial_tx_line = m[0];
      tick(3);
      `CHK("z_oe", m[1] ? ~m[0] : 1'b1, port_pin_zero_oe)
      `CHK("z_o", m[1] ? 1'b0 : m[0], port_pin_zero_o)
      `CHK("z_pu", 1'b1, port_pin_zero_pu)
      `CHK("role", u0pr_pkg::U0PR_ROLE_SER_OUT, pin_zero_role)
      `CHK("rx_one", 1'b1, serial_rx_line)
    end
    for (int m = 0; m < 4; m++) begin
      cfg({1'b0, m[1], 6'b101001, m[0], 1'b1});
      rem_val = m[0];
      serial_tx_line = ~m[0];
      tick(3);
      `CHK("z_o", m[1] ^ m[0], port_pin_zero_o)
      `CHK("z_oe", 1'b1, port_pin_zero_oe)
      `CHK("o_oe", 1'b0, port_pin_one_oe)
      `CHK("o_pu", 1'b0, port_pin_one_pu)
      `CHK("rx", m[0], serial_rx_line)
      `CHK("in_one", m[0], port_in_one)
    end
    rem_on_one = 1'b0;
    rem_on_zero = 1'b1;
    for (int m = 0; m < 2; m++) begin
      cfg({5'b10100, m[0], 1'b0, m[0], 1'b0, ~m[0]});
      rem_val = m[0];
      tick(3);
      `CHK("role", u0pr_pkg::U0PR_ROLE_SER_IN, pin_zero_role)
      `CHK("z_oe", 1'b0, port_pin_zero_oe)
      `CHK("rx", m[0], serial_rx_line)
      `CHK("in_zero", m[0], port_in_zero)
      `CHK("o_o", ~m[0], port_pin_one_o)
      `CHK("o_oe", m[0], port_pin_one_oe)
      `CHK("o_pu", m[0], port_pin_one_pu)
    end
    for (int i = 0; i < 2; i++) begin
      // both table rates stay well under the channel ceiling
      baud_compare = i ? u0pr_pkg::CMP_EX_31250 : u0pr_pkg::CMP_EX_9615;
      baud_run = 1'b1;
      n = 0;
      while (baud_bit_tick !== 1'b1 && n < 2000) begin
        tick(1);
        n++;
      end
      n = 0;
      k = 0;
      do begin
        tick(1);
        n++;
        k += int'(baud_overflow);
      end while (baud_bit_tick !== 1'b1 && n < 2000);
      `CHK("bit_cyc", (int'(baud_compare) + 1) * 2 * 8, n)
      `CHK("ovf_cnt", 16, k)
      `CHK("rate", i ? 31250 : 9615, OSC_HZ / n)
      baud_run = 1'b0;
      tick(2);
    end
    test_done();
  end
endmodule : u0pr_top_tb
`default_nettype wire
